// ==== rtl/nvw_core.sv ====
// cpu core end: runs the firmware access sequences for eeprom reads and writes
// assumes a software port on sys_clk and the device end on the same clock
`timescale 1ns/1ps
`include "nvw_regs.svh"
module nvw_core (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // link to the eeprom control end
  nvw_if.core             bus,
  // software port
  input  wire logic [3:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic      [7:0] sw_rdata,
  // core condition
  input  wire logic       stack_full
);

  nvw_pkg::nvw_host_s s_r;
  nvw_pkg::nvw_host_s s_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // one step of the access sequence; enables and starts go in separate writes
  function automatic nvw_pkg::nvw_op_s seq_op(input logic is_wr, input logic [3:0] step,
                                             input logic [`NVW_AW-1:0] a,
                                             input logic [7:0] d, input logic ien);
    nvw_pkg::nvw_op_s o;
    o = '{nvw_pkg::OP_END, 8'h00, 8'h00};
    // one table per direction; patterns stay in plain assignments so their type is known
    if (is_wr) begin
      unique case (step)
        4'h0: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_INTC, {7'h00, ien}};
        4'h1: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_ADDR, {3'h0, a}};
        4'h2: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_DATA, d};
        4'h3: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_MP1, `NVW_CTRL_PTR};
        4'h4: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_BP, `NVW_CTRL_BANK};
        4'h5: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h08};
        4'h6: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h0c};
        4'h7: o = '{nvw_pkg::OP_POLL, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h00};
        4'h8: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h00};
        4'h9: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_BP, `NVW_BP_RST};
        default: o = '{nvw_pkg::OP_END, 8'h00, 8'h00};
      endcase
    end else begin
      unique case (step)
        4'h0: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_INTC, {7'h00, ien}};
        4'h1: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_ADDR, {3'h0, a}};
        4'h2: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_MP1, `NVW_CTRL_PTR};
        4'h3: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_BP, `NVW_CTRL_BANK};
        4'h4: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h02};
        4'h5: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h03};
        4'h6: o = '{nvw_pkg::OP_POLL, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h00};
        4'h7: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h00};
        4'h8: o = '{nvw_pkg::OP_WRITE, `NVW_SFR_BP, `NVW_BP_RST};
        4'h9: o = '{nvw_pkg::OP_FETCH, `NVW_SFR_DATA, 8'h00};
        default: o = '{nvw_pkg::OP_END, 8'h00, 8'h00};
      endcase
    end
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state: software port, sequencer, interrupt service
  always_comb begin
    nvw_pkg::nvw_op_s op;
    logic             poll_bit;
    op = seq_op(s_r.is_wr, s_r.step, s_r.addr, s_r.data, s_r.ien);
    poll_bit = s_r.is_wr ? bus.sfr_rdata[`NVW_CB_WR] : bus.sfr_rdata[`NVW_CB_RD];
    s_nxt = s_r;
    s_nxt.sfr_wr = 1'b0;
    s_nxt.sfr_rd = 1'b0;
    s_nxt.sw_rdata = 8'h00;
    s_nxt.stack_full = stack_full;
    // software writes; a command while busy is dropped
    if (sw_wr) begin
      case (sw_addr)
        `NVW_H_CMD: if (!s_r.busy && (sw_wdata[`NVW_HC_WRITE] || sw_wdata[`NVW_HC_READ])) begin
          s_nxt.is_wr = sw_wdata[`NVW_HC_WRITE];
          s_nxt.st    = nvw_pkg::HS_RUN;
          s_nxt.step  = 4'h0;
          s_nxt.busy  = 1'b1;
          s_nxt.done  = 1'b0;
        end
        `NVW_H_ADDR: s_nxt.addr = sw_wdata[`NVW_AW-1:0];
        `NVW_H_DATA: s_nxt.data = sw_wdata;
        `NVW_H_STAT: if (sw_wdata[`NVW_HS_IRQ]) s_nxt.irq_seen = 1'b0;
        `NVW_H_CFG: begin
          s_nxt.gie = sw_wdata[`NVW_HF_GIE];
          s_nxt.ien = sw_wdata[`NVW_HF_IEN];
        end
        default: ;
      endcase
    end
    // software reads, answered one cycle later
    if (sw_rd) begin
      case (sw_addr)
        `NVW_H_ADDR:  s_nxt.sw_rdata = {3'h0, s_r.addr};
        `NVW_H_DATA:  s_nxt.sw_rdata = s_r.data;
        `NVW_H_STAT:  s_nxt.sw_rdata = {5'h00, s_r.irq_seen, s_r.done, s_r.busy};
        `NVW_H_RDATA: s_nxt.sw_rdata = s_r.rdata;
        `NVW_H_CFG:   s_nxt.sw_rdata = {6'h00, s_r.ien, s_r.gie};
        default:      s_nxt.sw_rdata = 8'h00;
      endcase
    end
    // sequencer: one core access per cycle, polls wait a cycle for read data
    unique case (s_r.st)
      nvw_pkg::HS_IDLE: ;
      nvw_pkg::HS_RUN: begin
        s_nxt.sfr_addr  = op.addr;
        s_nxt.sfr_wdata = op.data;
        unique case (op.kind)
          nvw_pkg::OP_WRITE: begin
            s_nxt.sfr_wr = 1'b1;
            s_nxt.step   = s_r.step + 4'h1;
          end
          nvw_pkg::OP_POLL, nvw_pkg::OP_FETCH: begin
            s_nxt.sfr_rd = 1'b1;
            s_nxt.st     = nvw_pkg::HS_WAIT;
          end
          nvw_pkg::OP_END: begin
            s_nxt.st   = nvw_pkg::HS_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
          end
        endcase
      end
      nvw_pkg::HS_WAIT: begin
        // let the strobe cycle pass; the answer stands only in the cycle after it
        if (!s_r.sfr_rd) begin
          s_nxt.st = nvw_pkg::HS_RUN;
          if (op.kind == nvw_pkg::OP_FETCH) begin
            s_nxt.rdata = bus.sfr_rdata;
            s_nxt.step  = s_r.step + 4'h1;
          end else if (!poll_bit) begin
            s_nxt.step = s_r.step + 4'h1;
          end
        end
      end
      default: s_nxt.st = nvw_pkg::HS_IDLE;
    endcase
    // service a vectored request once; the ack pulse clears the device flag
    s_nxt.irq_ack = bus.irq_vec && !s_r.irq_ack;
    if (bus.irq_vec && !s_r.irq_ack) s_nxt.irq_seen = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign sw_rdata           = s_r.sw_rdata;
  assign bus.sfr_addr       = s_r.sfr_addr;
  assign bus.sfr_wdata      = s_r.sfr_wdata;
  assign bus.sfr_wr         = s_r.sfr_wr;
  assign bus.sfr_rd         = s_r.sfr_rd;
  assign bus.cpu_gie        = s_r.gie;
  assign bus.cpu_stack_full = s_r.stack_full;
  assign bus.irq_ack        = s_r.irq_ack;

endmodule

// ==== rtl/nvw_device.sv ====
// eeprom control end: address, data and control registers, write cycle, done interrupt
// assumes the core end on sys_clk and a write timer that answers on its own clock
`timescale 1ns/1ps
`include "nvw_regs.svh"

// Function
// - firmware sets write enable before writing
// - firmware loads address and data first
// - start with enable begins write cycle
// - start without enable does nothing
// - external asynchronous timer times each write
// - hardware clears write start when done
// - write end sets done request flag
// - firmware enables done interrupt first
// - vector needs global, local enable, stack room
// - servicing clears done flag automatically
// - reset clears write enable
// - reset clears bank selector to zero
// - control reached via pointer 40h, bank 1
// - read: enable, start, poll start bit
// - write: enable, then start, then poll
// - afterwards clear control and bank selector
// - keep write enable low when idle
// - optional read back of written byte
// - 32 bytes, five address bits, upper zero
// - never enable and start together
// - read byte held until next access
// - control resets zero, bits 7-4 zero
module nvw_device (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // link to the cpu core end
  nvw_if.device     bus,
  // self-timed write timer
  output logic      wt_req,
  input  wire logic wt_done
);

  nvw_pkg::nvw_dev_s s_r;
  nvw_pkg::nvw_dev_s s_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // the indirect port reaches control only at the right pointer and bank
  function automatic logic ctrl_sel(input logic [7:0] bp, input logic [7:0] mp1);
    return (bp == `NVW_CTRL_BANK) && (mp1 == `NVW_CTRL_PTR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [7:0] wv;
    logic       flag_set;
    logic       flag_clr;
    logic       start_wr;
    wv       = bus.sfr_wdata;
    flag_set = 1'b0;
    flag_clr = 1'b0;
    start_wr = 1'b0;
    s_nxt    = s_r;
    // two-flop synchroniser; only done_s2 is looked at
    s_nxt.done_s1 = wt_done;
    s_nxt.done_s2 = s_r.done_s1;
    // a read takes one cycle, then the byte sits in data until the next access
    if (s_r.rd) begin
      s_nxt.data = s_r.mem[s_r.addr];
      s_nxt.rd   = 1'b0;
    end
    // write cycle: request level to the timer, wait for done, then for done to drop
    unique case (s_r.wst)
      nvw_pkg::WS_IDLE: ;
      nvw_pkg::WS_REQ: if (s_r.done_s2) begin
        s_nxt.mem[s_r.wr_addr] = s_r.wr_data;
        s_nxt.wr     = 1'b0;
        flag_set     = 1'b1;
        s_nxt.wt_req = 1'b0;
        s_nxt.wst    = nvw_pkg::WS_DROP;
      end
      nvw_pkg::WS_DROP: if (!s_r.done_s2) s_nxt.wst = nvw_pkg::WS_IDLE;
      default: s_nxt.wst = nvw_pkg::WS_IDLE;
    endcase
    // register writes from the core
    if (bus.sfr_wr) begin
      case (bus.sfr_addr)
        `NVW_SFR_INDIRECT_ACCESS_PORT_1: if (ctrl_sel(s_r.bp, s_r.mp1)) begin
          s_nxt.nv_write_enable = wv[`NVW_CB_NV_WRITE_ENABLE];
          s_nxt.nv_read_enable = wv[`NVW_CB_NV_READ_ENABLE];
          // starts count only against enables already set, and only when idle
          if (s_r.wst == nvw_pkg::WS_IDLE) begin
            start_wr = wv[`NVW_CB_WR] && s_r.nv_write_enable;
            s_nxt.wr = start_wr;
            if (start_wr) begin
              s_nxt.wr_addr = s_r.addr;
              s_nxt.wr_data = s_r.data;
              s_nxt.wt_req  = 1'b1;
              s_nxt.wst     = nvw_pkg::WS_REQ;
            end else if (wv[`NVW_CB_RD] && s_r.nv_read_enable) begin
              s_nxt.rd = 1'b1;
            end
          end
        end
        `NVW_SFR_MP1:  s_nxt.mp1  = wv;
        `NVW_SFR_BP:   s_nxt.bp   = wv;
        `NVW_SFR_ADDR: s_nxt.addr = wv[`NVW_AW-1:0];
        `NVW_SFR_DATA: s_nxt.data = wv;
        `NVW_SFR_INTC: begin
          s_nxt.ien = wv[`NVW_IC_EN];
          flag_clr  = !wv[`NVW_IC_FLAG];
        end
        default: ;
      endcase
    end
    // servicing the vector clears the flag; a new write end in the same cycle wins
    if (bus.irq_ack) flag_clr = 1'b1;
    s_nxt.flag = (s_r.flag && !flag_clr) || flag_set;
    // read data stands only in the cycle after the strobe
    s_nxt.rdata = 8'h00;
    if (bus.sfr_rd) begin
      case (bus.sfr_addr)
        `NVW_SFR_INDIRECT_ACCESS_PORT_1: if (ctrl_sel(s_r.bp, s_r.mp1)) begin
          s_nxt.rdata = {4'h0, s_r.nv_write_enable, s_r.wr, s_r.nv_read_enable, s_r.rd};
        end
        `NVW_SFR_MP1:  s_nxt.rdata = s_r.mp1;
        `NVW_SFR_BP:   s_nxt.rdata = s_r.bp;
        `NVW_SFR_ADDR: s_nxt.rdata = {3'h0, s_r.addr};
        `NVW_SFR_DATA: s_nxt.rdata = s_r.data;
        `NVW_SFR_INTC: s_nxt.rdata = {6'h00, s_r.flag, s_r.ien};
        default:       s_nxt.rdata = 8'h00;
      endcase
    end
    // vector request only with both enables and room on the stack
    s_nxt.irq_vec = s_nxt.flag && s_nxt.ien && bus.cpu_gie && !bus.cpu_stack_full;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register; everything, the array included, clears at power-on
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign wt_req        = s_r.wt_req;
  assign bus.sfr_rdata = s_r.rdata;
  assign bus.irq_vec   = s_r.irq_vec;

endmodule

// ==== rtl/nvw_if.sv ====
// link between the cpu core end and the eeprom control end
// assumes both ends run on the same sys_clk
`timescale 1ns/1ps
interface nvw_if;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_rdata;
  logic       cpu_gie;
  logic       cpu_stack_full;
  logic       irq_vec;
  logic       irq_ack;

  modport device (
    input  sfr_addr, sfr_wdata, sfr_wr, sfr_rd, cpu_gie, cpu_stack_full, irq_ack,
    output sfr_rdata, irq_vec
  );
  modport core (
    output sfr_addr, sfr_wdata, sfr_wr, sfr_rd, cpu_gie, cpu_stack_full, irq_ack,
    input  sfr_rdata, irq_vec
  );
endinterface

// ==== rtl/nvw_pkg.sv ====
// types shared by the eeprom control ends
// assumes nvw_regs.svh on the include path
package nvw_pkg;
  `include "nvw_regs.svh"

  // write cycle handshake with the self-timed write timer
  typedef enum logic [1:0] {WS_IDLE, WS_REQ, WS_DROP} nvw_wst_e;

  // controller sequencer states
  typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_WAIT} nvw_hst_e;

  // kind of one core access in a sequence
  typedef enum logic [1:0] {OP_END, OP_WRITE, OP_POLL, OP_FETCH} nvw_opk_e;

  typedef struct packed {
    nvw_opk_e   kind;
    logic [7:0] addr;
    logic [7:0] data;
  } nvw_op_s;

  typedef struct packed {
    logic [`NVW_DEPTH-1:0][7:0] mem;
    logic [7:0]                 mp1;
    logic [7:0]                 bp;
    logic [`NVW_AW-1:0]         addr;
    logic [7:0]                 data;
    logic                       nv_write_enable;
    logic                       wr;
    logic                       nv_read_enable;
    logic                       rd;
    logic                       ien;
    logic                       flag;
    logic [`NVW_AW-1:0]         wr_addr;
    logic [7:0]                 wr_data;
    nvw_wst_e                   wst;
    logic                       wt_req;
    logic                       done_s1;
    logic                       done_s2;
    logic [7:0]                 rdata;
    logic                       irq_vec;
  } nvw_dev_s;

  typedef struct packed {
    nvw_hst_e           st;
    logic               is_wr;
    logic [3:0]         step;
    logic [`NVW_AW-1:0] addr;
    logic [7:0]         data;
    logic [7:0]         rdata;
    logic               busy;
    logic               done;
    logic               irq_seen;
    logic               gie;
    logic               ien;
    logic [7:0]         sfr_addr;
    logic [7:0]         sfr_wdata;
    logic               sfr_wr;
    logic               sfr_rd;
    logic               irq_ack;
    logic               stack_full;
    logic [7:0]         sw_rdata;
  } nvw_host_s;
endpackage

// ==== rtl/nvw_regs.svh ====
// constants of the data-eeprom write control: register map, bit positions, reset values
// assumes inclusion by its bare name from the package and both ends
`ifndef NVW_REGS_SVH
`define NVW_REGS_SVH

// special function registers seen by the core, bank 0 unless noted
`define NVW_SFR_INDIRECT_ACCESS_PORT_1     8'h02
`define NVW_SFR_MP1      8'h03
`define NVW_SFR_BP       8'h04
`define NVW_SFR_INTC     8'h0e
`define NVW_SFR_ADDR     8'h1e
`define NVW_SFR_DATA     8'h1f

// control register sits behind the indirect port at this pointer and bank
`define NVW_CTRL_PTR     8'h40
`define NVW_CTRL_BANK    8'h01

// control register bit positions
`define NVW_CB_RD        0
`define NVW_CB_NV_READ_ENABLE      1
`define NVW_CB_WR        2
`define NVW_CB_NV_WRITE_ENABLE      3

// interrupt control bit positions
`define NVW_IC_EN        0
`define NVW_IC_FLAG      1

// array geometry
`define NVW_DEPTH        32
`define NVW_AW           5

// reset values
`define NVW_CTRL_RST     4'h0
`define NVW_BP_RST       8'h00

// controller software port map
`define NVW_H_CMD        4'h0
`define NVW_H_ADDR       4'h1
`define NVW_H_DATA       4'h2
`define NVW_H_STAT       4'h3
`define NVW_H_RDATA      4'h4
`define NVW_H_CFG        4'h5

// controller field positions
`define NVW_HC_READ      0
`define NVW_HC_WRITE     1
`define NVW_HS_BUSY      0
`define NVW_HS_DONE      1
`define NVW_HS_IRQ       2
`define NVW_HF_GIE       0
`define NVW_HF_IEN       1

`endif

// ==== verification/eeprom_write_control_tb.sv ====
// bench: core end and device end joined, plus a second device driven directly
// assumes the design files and nvw_regs.svh on the include path
`timescale 1ns/1ps
`include "nvw_regs.svh"
module eeprom_write_control_tb;
  logic       sys_clk     = 1'b0;
  logic       rst_b       = 1'b0;
  logic [3:0] sw_addr     = 4'h0;
  logic [7:0] sw_wdata    = 8'h00;
  logic       sw_wr       = 1'b0;
  logic       sw_rd       = 1'b0;
  logic [7:0] sw_rdata;
  logic       stack_full  = 1'b0;
  logic       wt_req1;
  logic       wt_req2;
  logic       wt_done1    = 1'b0;
  logic       wt_done2    = 1'b0;
  int         tdel1       = 3;
  int         fails       = 0;
  int         checks_done = 0;
  logic [7:0] r;
  // write/readback table: address, data, config, expected status, timer delay
  logic [7:0] ta [3] = '{8'h05, 8'h1f, 8'h00};
  logic [7:0] td [3] = '{8'ha5, 8'h3c, 8'h5a};
  logic [7:0] tc [3] = '{8'h03, 8'h01, 8'h03};
  logic [7:0] tx [3] = '{8'h06, 8'h02, 8'h02};
  int         tw [3] = '{3, 40, 1};
  logic [2:0] tf      = 3'b100;

  nvw_if if1 ();
  nvw_if if2 ();
  nvw_core i_nvw_core (.sys_clk(sys_clk), .rst_b(rst_b), .bus(if1), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .stack_full(stack_full));
  nvw_device i_nvw_device (.sys_clk(sys_clk), .rst_b(rst_b), .bus(if1),
    .wt_req(wt_req1), .wt_done(wt_done1));
  nvw_device i_nvw_device_b (.sys_clk(sys_clk), .rst_b(rst_b), .bus(if2),
    .wt_req(wt_req2), .wt_done(wt_done2));
  nvw_checker i_nvw_checker (.sys_clk(sys_clk), .rst_b(rst_b), .sfr_addr(if1.sfr_addr),
    .sfr_wdata(if1.sfr_wdata), .sfr_wr(if1.sfr_wr), .sfr_rd(if1.sfr_rd),
    .sfr_rdata(if1.sfr_rdata), .cpu_gie(if1.cpu_gie), .cpu_stack_full(if1.cpu_stack_full),
    .irq_vec(if1.irq_vec), .irq_ack(if1.irq_ack), .wt_req(wt_req1), .wt_done(wt_done1));

  ////////////////////////////////////////////////////////////////
  // 250 mhz clock
  always #2 sys_clk = ~sys_clk;
  // write timers: off-phase done, held until the request drops (four-phase)
  always begin
    @(posedge wt_req1);
    repeat (tdel1) @(posedge sys_clk);
    #1.3 wt_done1 = 1'b1;
    @(negedge wt_req1);
    #0.7 wt_done1 = 1'b0;
  end
  always begin
    @(posedge wt_req2);
    repeat (20) @(posedge sys_clk);
    #1.3 wt_done2 = 1'b1;
    @(negedge wt_req2);
    #0.7 wt_done2 = 1'b0;
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one access: p selects the direct device port, else the software port
  task automatic acc(input bit p, input bit w, input logic [7:0] a, input logic [7:0] d);
    if (p) begin
      if2.sfr_addr <= a;
      if2.sfr_wdata <= d;
      if2.sfr_wr <= w;
      if2.sfr_rd <= !w;
    end else begin
      sw_addr <= a[3:0];
      sw_wdata <= d;
      sw_wr <= w;
      sw_rd <= !w;
    end
    @(posedge sys_clk);
    if2.sfr_wr <= 1'b0;
    if2.sfr_rd <= 1'b0;
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    #1 r = p ? if2.sfr_rdata : sw_rdata;
    @(posedge sys_clk);
  endtask
  task automatic wr(input bit p, input logic [7:0] a, input logic [7:0] d);
    acc(p, 1'b1, a, d);
  endtask
  task automatic chk(input bit p, input logic [7:0] a, input logic [7:0] e);
    acc(p, 1'b0, a, 8'h00);
    cmp(r, e);
  endtask
  // bounded poll until the masked bits match
  task automatic poll(input bit p, input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] v);
    int n;
    for (n = 0; n < 300; n++) begin
      acc(p, 1'b0, a, 8'h00);
      if ((r & m) === v) break;
    end
    if (n == 300) begin
      fails++;
      $display("CHECK FAILED at %0t: poll got %h expected %h", $time, r & m, v);
      end_sim();
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    if2.sfr_addr = 8'h00;
    if2.sfr_wdata = 8'h00;
    if2.sfr_wr = 1'b0;
    if2.sfr_rd = 1'b0;
    if2.cpu_gie = 1'b0;
    if2.cpu_stack_full = 1'b0;
    if2.irq_ack = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    // reset state: bank 0 hides the control register
    chk(0, `NVW_H_STAT, 8'h00);
    wr(1, `NVW_SFR_MP1, 8'h40);
    chk(1, `NVW_SFR_BP, 8'h00);
    chk(1, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h00);
    wr(1, `NVW_SFR_BP, 8'h01);
    chk(1, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h00);
    $display("test 1 done");
    // full write and readback through the core, prompt and slow timer
    for (int k = 0; k < 3; k++) begin
      stack_full <= tf[k];
      tdel1 = tw[k];
      wr(0, `NVW_H_STAT, 8'h04);
      wr(0, `NVW_H_CFG, tc[k]);
      wr(0, `NVW_H_ADDR, ta[k]);
      wr(0, `NVW_H_DATA, td[k]);
      wr(0, `NVW_H_CMD, 8'h02);
      poll(0, `NVW_H_STAT, 8'h03, 8'h02);
      chk(0, `NVW_H_STAT, tx[k]);
      wr(0, `NVW_H_STAT, 8'h04);
      wr(0, `NVW_H_CMD, 8'h01);
      poll(0, `NVW_H_STAT, 8'h03, 8'h02);
      chk(0, `NVW_H_RDATA, td[k]);
      chk(0, `NVW_H_STAT, 8'h02);
      $display("test 2.%0d done", k);
    end
    // direct port: refused start, address width, busy latches, read hold
    wr(1, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h0c);
    chk(1, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h08);
    cmp({7'h00, wt_req2}, 8'h00);
    wr(1, `NVW_SFR_ADDR, 8'hff);
    chk(1, `NVW_SFR_ADDR, 8'h1f);
    wr(1, `NVW_SFR_ADDR, 8'h02);
    wr(1, `NVW_SFR_DATA, 8'h77);
    wr(1, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h0c);
    wr(1, `NVW_SFR_DATA, 8'h11);
    wr(1, `NVW_SFR_ADDR, 8'h03);
    wr(1, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h08);
    chk(1, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h0c);
    poll(1, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h04, 8'h00);
    chk(1, `NVW_SFR_INTC, 8'h02);
    wr(1, `NVW_SFR_INTC, 8'h00);
    chk(1, `NVW_SFR_INTC, 8'h00);
    wr(1, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h00);
    wr(1, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h02);
    wr(1, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h03);
    poll(1, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h01, 8'h00);
    chk(1, `NVW_SFR_DATA, 8'h00);
    wr(1, `NVW_SFR_ADDR, 8'h02);
    wr(1, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h03);
    poll(1, `NVW_SFR_INDIRECT_ACCESS_PORT_1, 8'h01, 8'h00);
    chk(1, `NVW_SFR_DATA, 8'h77);
    wr(1, `NVW_SFR_ADDR, 8'h05);
    chk(1, `NVW_SFR_DATA, 8'h77);
    $display("test 3 done");
    end_sim();
  end
endmodule

// ==== verification/nvw_checker.sv ====
// checker for the core-to-eeprom link and the write timer handshake
// assumes both ends on sys_clk and the constants of nvw_regs.svh
`timescale 1ns/1ps
`include "nvw_regs.svh"
module nvw_checker (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_b,
  // link signals
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       cpu_gie,
  input wire logic       cpu_stack_full,
  input wire logic       irq_vec,
  input wire logic       irq_ack,
  // write timer handshake
  input wire logic       wt_req,
  input wire logic       wt_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////
  // vector only with the global enable of the cycle before and stack room
  property p_vec_mask;
    irq_vec |-> $past(cpu_gie) && !$past(cpu_stack_full);
  endproperty
  a_vec_mask: assert property (p_vec_mask) else $error("vector without enables");
  // a write cycle starts only from a start bit written to the indirect port
  property p_start_cause;
    $rose(wt_req) |-> $past(sfr_wr) && $past(sfr_addr) == `NVW_SFR_INDIRECT_ACCESS_PORT_1
      && $past(sfr_wdata[`NVW_CB_WR]);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("write began uncommanded");
  // the async done passes two flops before it may end the cycle
  property p_sync_hold;
    $rose(wt_done) && wt_req |=> wt_req ##1 wt_req;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("done used unsynchronised");
  // the timer, not a fixed count, ends the cycle, and promptly
  property p_end_bound;
    $rose(wt_done) && wt_req |-> ##[1:4] !wt_req;
  endproperty
  a_end_bound: assert property (p_end_bound) else $error("write did not end on done");
  // servicing drops the request
  property p_ack_clears;
    irq_ack && !wt_req |=> !irq_vec;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("flag kept after service");
  // unimplemented control bits read as zero
  property p_ctrl_upper;
    sfr_rd && sfr_addr == `NVW_SFR_INDIRECT_ACCESS_PORT_1 |=> sfr_rdata[7:4] == 4'h0;
  endproperty
  a_ctrl_upper: assert property (p_ctrl_upper) else $error("control upper bits set");
  // start bit stays up while the timer has not answered
  property p_wr_busy;
    sfr_rd && sfr_addr == `NVW_SFR_INDIRECT_ACCESS_PORT_1 && wt_req && !wt_done |=> sfr_rdata[`NVW_CB_WR];
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("start bit lost while busy");
  // start bit reads zero once the cycle is over
  property p_wr_clear;
    sfr_rd && sfr_addr == `NVW_SFR_INDIRECT_ACCESS_PORT_1 && !wt_req |=> !sfr_rdata[`NVW_CB_WR];
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("start bit not cleared");
  // main scenarios reached
  c_start: cover property ($rose(wt_req));
  c_end: cover property ($fell(wt_req));
  c_ack: cover property (irq_ack);
endmodule
